// ---- dv/i2c_master_model.sv ----
`timescale 1ns/1ps
module i2c_master_model (
	output logic link_scl,
	output logic sda_in,
	input wire logic sda_oe
);
	logic pull_low = 1'b0;
	// released line floats to the pull-up level
	assign sda_in = ~(pull_low | sda_oe);
	initial begin
		link_scl = 1'b1;
	end
	// data moves mid-low, sampled mid-high
	task automatic bit_cycle(input logic val, output logic got);
		pull_low = ~val;
		#20 link_scl = 1'b1;
		#20 got = sda_in;
		#20 link_scl = 1'b0;
		#20;
	endtask : bit_cycle
	// master_ack 0 releases the line; send 8'hFF to read
	task automatic xfer(input logic [7:0] tx, input logic master_ack, output logic [7:0] rx,
		output logic acked);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(tx[i], b);
			rx[i] = b;
		end
		bit_cycle(~master_ack, b);
		acked = ~b;
	endtask : xfer
	// odd offset keeps the link out of phase with the system clock
	task automatic start_cond();
		#13 pull_low = 1'b0;
		#20 link_scl = 1'b1;
		#20 pull_low = 1'b1;
		#20 link_scl = 1'b0;
		#20;
	endtask : start_cond
	task automatic stop_cond();
		pull_low = 1'b1;
		#20 link_scl = 1'b1;
		#20 pull_low = 1'b0;
		#40;
	endtask : stop_cond
endmodule : i2c_master_model

// ---- dv/pmic_serial_control_asserts.sv ----
`timescale 1ns/1ps
module pmic_serial_control_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_scl,
	input wire logic sda_in,
	input wire logic sda_oe,
	input wire logic logic_supply_low,
	input wire logic powerdown_state_one,
	input wire logic powerdown_state_two,
	input wire pmic_regs_pkg::regulator_control_t regulator_control,
	input wire pmic_regs_pkg::led_boost_control_t led_boost_control,
	input wire pmic_regs_pkg::led_current_code_t led_current_code,
	input wire pmic_regs_pkg::led_pulse_ratio_t led_pulse_ratio,
	input wire logic led_pulse_on
);
	// *****
	// link bit tracking
	// *****
	logic start_q;
	logic seen_q;
	logic first_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	wire logic clr = logic_supply_low | powerdown_state_one | powerdown_state_two;
	wire logic [31:0] regs = {regulator_control, led_boost_control, led_current_code,
		led_pulse_ratio};
	wire logic boost = led_boost_control.boost_on;
	wire logic pulsed = led_boost_control.boost_select_hi & ~led_boost_control.boost_select_lo;
	wire logic [3:0] num = led_pulse_ratio.pulse_numerator;
	// a start toggles a flag, so the scl side sees it without a second driver
	always_ff @(negedge sda_in or posedge rst) begin
		if (rst) begin
			start_q <= 1'b0;
		end else if (link_scl) begin
			start_q <= ~start_q;
		end
	end
	always_ff @(posedge link_scl or posedge rst) begin
		if (rst) begin
			seen_q <= 1'b0;
			first_q <= 1'b0;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
		end else begin
			seen_q <= start_q;
			first_q <= (seen_q != start_q) | (first_q & (cnt_q != 4'h9));
			cnt_q <= (seen_q != start_q || cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
			sh_q <= {sh_q[6:0], sda_in};
		end
	end
	chk_addr_ack: assert property (@(posedge link_scl) disable iff (rst)
		cnt_q == 4'h8 && first_q |-> sda_oe == (sh_q[7:1] == 7'h09)) else $error("addr ack");
	chk_ack_stable: assert property (@(posedge clk) disable iff (rst)
		link_scl && $past(link_scl) |-> $stable(sda_oe)) else $error("data moved, scl high");
	chk_commit_stop: assert property (@(posedge clk) disable iff (rst)
		$changed(regs) && regs != 32'h0000_0000 |-> link_scl) else $error("update, no stop");
	chk_clear_regs: assert property (@(posedge clk) disable iff (rst)
		$rose(clr) |-> ##[1:5] regs == 32'h0000_0000) else $error("clear missed");
	chk_pulse_off: assert property (@(posedge clk) disable iff (rst)
		!boost |=> !led_pulse_on) else $error("pulse while off");
	chk_pulse_steady: assert property (@(posedge clk) disable iff (rst)
		boost && !pulsed |=> led_pulse_on) else $error("steady drive off");
	chk_pulse_zero: assert property (@(posedge clk) disable iff (rst)
		(boost && pulsed && num == 4'h0) [*2] |=> !led_pulse_on) else $error("zero duty");
	chk_pulse_full: assert property (@(posedge clk) disable iff (rst)
		(boost && pulsed && num > led_pulse_ratio.pulse_denominator) [*2] |=> led_pulse_on)
		else $error("full duty");
	cover property (@(posedge link_scl) disable iff (rst) cnt_q == 4'h8 && first_q && sda_oe);
	cover property (@(posedge clk) disable iff (rst) $changed(regs) && regs != 32'h0000_0000);
	cover property (@(posedge clk) disable iff (rst) $rose(led_pulse_on));
endmodule : pmic_serial_control_asserts

bind pmic_serial_control pmic_serial_control_asserts pmic_serial_control_asserts_inst (
	.clk(clk), .rst(rst), .link_scl(link_scl), .sda_in(sda_in), .sda_oe(sda_oe),
	.logic_supply_low(logic_supply_low), .powerdown_state_one(powerdown_state_one),
	.powerdown_state_two(powerdown_state_two), .regulator_control(regulator_control),
	.led_boost_control(led_boost_control), .led_current_code(led_current_code),
	.led_pulse_ratio(led_pulse_ratio), .led_pulse_on(led_pulse_on));

// ---- dv/test_pmic_serial_control.sv ----
`timescale 1ns/1ps
module test_pmic_serial_control;
	localparam int TICK = pmic_regs_pkg::TICK_CYC_0;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] clr = 3'b000;
	logic [7:0] status_in = 8'h00;
	logic link_scl;
	logic sda_in;
	logic sda_oe;
	logic led_pulse_on;
	logic sda_o;
	logic [7:0] rx;
	logic ack;
	pmic_regs_pkg::regulator_control_t regulator_control;
	pmic_regs_pkg::led_boost_control_t led_boost_control;
	pmic_regs_pkg::led_current_code_t led_current_code;
	pmic_regs_pkg::led_pulse_ratio_t led_pulse_ratio;
	wire logic [31:0] regs = {regulator_control, led_boost_control, led_current_code,
		led_pulse_ratio};
	int n_fail = 0;
	int samples_checked = 0;
	int hi = 0;
	always #20 clk = ~clk;
	pmic_serial_control pmic_serial_control_inst (.clk(clk), .rst(rst), .link_scl(link_scl),
		.sda_in(sda_in), .sda_o(sda_o), .sda_oe(sda_oe), .logic_supply_low(clr[0]),
		.powerdown_state_one(clr[1]), .powerdown_state_two(clr[2]), .status_in(status_in),
		.regulator_control(regulator_control), .led_boost_control(led_boost_control),
		.led_current_code(led_current_code), .led_pulse_ratio(led_pulse_ratio),
		.led_pulse_on(led_pulse_on));
	i2c_master_model i2c_master_model_inst (.link_scl(link_scl), .sda_in(sda_in),
		.sda_oe(sda_oe));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	task automatic send(input logic [7:0] tx, input logic want);
		i2c_master_model_inst.xfer(tx, 1'b0, rx, ack);
		check(32'(ack), 32'(want));
	endtask : send
	task automatic wr(input logic [7:0] sub, input logic [7:0] data);
		i2c_master_model_inst.start_cond();
		send(8'h12, 1'b1);
		send(sub, 1'b1);
		send(data, 1'b1);
	endtask : wr
	task automatic stop_wait();
		i2c_master_model_inst.stop_cond();
		repeat (6) @(posedge clk);
		#1;
	endtask : stop_wait
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk);
		#1 check(regs, 32'h0000_0000);
		check(32'(sda_o), 32'h0);
		wr(8'h00, 8'h6D);
		wr(8'h01, 8'hA5);
		i2c_master_model_inst.start_cond();
		send(8'h20, 1'b0);
		wr(8'h02, 8'hC3);
		wr(8'h03, 8'h5A);
		send(8'h01, 1'b0);
		check(regs, 32'h0000_0000);
		stop_wait();
		check(regs, 32'h6DA5_C35A);
		check(32'({regulator_control.switch_edge_rate_hi, led_boost_control.ramp_time_lo}),
			32'h3);
		check(32'(led_pulse_on), 32'h1);
		wr(8'h05, 8'h11);
		wr(8'h03, 8'h77);
		wr(8'h03, 8'h00);
		stop_wait();
		check(regs, 32'h6D11_C300);
		check(32'(led_pulse_on), 32'h0);
		wr(8'h03, 8'h12);
		stop_wait();
		// one tick high out of two, over two whole periods
		repeat (4 * TICK) begin
			@(posedge clk);
			#1 if (led_pulse_on === 1'b1) hi++;
		end
		check(32'(hi > 2 * TICK - 9 && hi < 2 * TICK + 9), 32'h1);
		status_in = 8'hA6;
		repeat (3) @(posedge clk);
		i2c_master_model_inst.start_cond();
		send(8'h13, 1'b1);
		i2c_master_model_inst.xfer(8'hFF, 1'b0, rx, ack);
		check(32'(rx), 32'hA6);
		check(32'(ack), 32'h0);
		i2c_master_model_inst.start_cond();
		send(8'h11, 1'b0);
		wr(8'h00, 8'h03);
		stop_wait();
		check(32'(regulator_control), 32'h03);
		for (int i = 0; i < 3; i++) begin
			clr[i] = 1'b1;
			repeat (6) @(posedge clk);
			#1 check(regs, 32'h0000_0000);
			clr[i] = 1'b0;
			repeat (6) @(posedge clk);
			#1 wr(8'h02, 8'h3F);
			stop_wait();
			check(regs, 32'h0000_3F00);
		end
		report_and_stop();
	end
	initial begin
		#2_000_000;
		n_fail++;
		$display("Error at %0t: timeout", $time);
		report_and_stop();
	end
endmodule : test_pmic_serial_control

// ---- rtl/pmic_regs_pkg.sv ----
package pmic_regs_pkg;

	// ****************************************
	// bus addressing
	// ****************************************
	localparam logic [6:0] SLAVE_ADDR = 7'h09;
	localparam logic [7:0] WRITE_ADDR_BYTE = {SLAVE_ADDR, 1'b0};
	localparam logic [7:0] READ_ADDR_BYTE = {SLAVE_ADDR, 1'b1};
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [1:0] SUB_REGULATOR = 2'h0;
	localparam logic [1:0] SUB_LED_BOOST = 2'h1;
	localparam logic [1:0] SUB_LED_CURRENT = 2'h2;
	localparam logic [1:0] SUB_LED_PULSE = 2'h3;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ****************************************
	// pulse clock timing
	// ****************************************
	localparam longint CLK_HZ = 25_000_000;
	localparam longint PULSE_CHZ_0 = 877_000;
	localparam longint PULSE_CHZ_1 = 439_000;
	localparam longint PULSE_CHZ_2 = 292_000;
	localparam longint PULSE_CHZ_3 = 219_000;
	localparam logic [11:0] TICK_CYC_0 = 12'((CLK_HZ * 100) / PULSE_CHZ_0);
	localparam logic [11:0] TICK_CYC_1 = 12'((CLK_HZ * 100) / PULSE_CHZ_1);
	localparam logic [11:0] TICK_CYC_2 = 12'((CLK_HZ * 100) / PULSE_CHZ_2);
	localparam logic [11:0] TICK_CYC_3 = 12'((CLK_HZ * 100) / PULSE_CHZ_3);

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_ADDR = 3'b001,
		PH_SUB = 3'b010,
		PH_DATA = 3'b011,
		PH_READ = 3'b100
	} phase_t;

	typedef enum logic [1:0] {
		BOOST_CONST_CURRENT = 2'b00,
		BOOST_FIXED_HV = 2'b01,
		BOOST_PULSED = 2'b10,
		BOOST_UNSUPPORTED = 2'b11
	} boost_mode_t;

	typedef struct packed {
		logic unused;
		logic switch_edge_rate_hi;
		logic switch_edge_rate_lo;
		logic stepdown_three_lowload;
		logic stepdown_two_lowload;
		logic stepdown_one_lowload;
		logic linreg_two_on;
		logic linreg_one_on;
	} regulator_control_t;

	typedef struct packed {
		logic backlight_edge_rate;
		logic pulse_clock_sel_hi;
		logic pulse_clock_sel_lo;
		logic boost_select_hi;
		logic boost_select_lo;
		logic ramp_time_lo;
		logic ramp_time_hi;
		logic boost_on;
	} led_boost_control_t;

	typedef struct packed {
		logic [1:0] unused;
		logic [5:0] current_step;
	} led_current_code_t;

	typedef struct packed {
		logic [3:0] pulse_numerator;
		logic [3:0] pulse_denominator;
	} led_pulse_ratio_t;

endpackage : pmic_regs_pkg

// ---- rtl/pmic_serial_control.sv ----
`timescale 1ns/1ps
module pmic_serial_control (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_scl,
	input wire logic sda_in,
	output logic sda_o,
	output logic sda_oe,
	input wire logic logic_supply_low,
	input wire logic powerdown_state_one,
	input wire logic powerdown_state_two,
	input wire logic [7:0] status_in,
	output pmic_regs_pkg::regulator_control_t regulator_control,
	output pmic_regs_pkg::led_boost_control_t led_boost_control,
	output pmic_regs_pkg::led_current_code_t led_current_code,
	output pmic_regs_pkg::led_pulse_ratio_t led_pulse_ratio,
	output logic led_pulse_on
);

	// ****************************************
	// functions
	// ****************************************
	// clock code to clk cycles per pulse clock tick, rounded down and cut to 12 bits, so the counts for codes 1 to 3 wrap
	function automatic logic [11:0] tick_limit(input logic [1:0] sel);
		case (sel)
			2'b00: tick_limit = pmic_regs_pkg::TICK_CYC_0;
			2'b01: tick_limit = pmic_regs_pkg::TICK_CYC_1;
			2'b10: tick_limit = pmic_regs_pkg::TICK_CYC_2;
			default: tick_limit = pmic_regs_pkg::TICK_CYC_3;
		endcase
	endfunction : tick_limit

	// true in the on part of a period; a numerator above the denominator,
	// or a zero denominator with a numerator set, means always on
	function automatic logic pulse_level(input logic [3:0] num, input logic [3:0] den,
			input logic [3:0] pos);
		pulse_level = (num != 4'h0) && ((num > den) || (pos < num));
	endfunction : pulse_level

	// ****************************************
	// clear sources
	// ****************************************
	logic [2:0] clr_meta_q;
	logic [2:0] clr_sync_q;
	logic wipe_q;
	logic link_rst;
	logic clear_req;

	// clears are levels from slow supervisors; three cycles of latency are
	// far below any supply collapse time
	assign clear_req = |clr_sync_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clr_meta_q <= 3'h0;
			clr_sync_q <= 3'h0;
			wipe_q <= 1'b0;
		end else begin
			clr_meta_q <= {logic_supply_low, powerdown_state_one, powerdown_state_two};
			clr_sync_q <= clr_meta_q;
			wipe_q <= clear_req;
		end
	end

	// the link side is cleared from a flop, so its reset never glitches
	// the release comes on clk, not scl; the bus is idle by then, so no
	// scl edge can meet it
	assign link_rst = rst | wipe_q;

	// ****************************************
	// start and stop detection
	// ****************************************
	// sda falling or rising while scl is high; toggles let the engine see
	// each event once without a pulse that would need its own clock
	// no glitch filter here: the pads are expected to clean the bus lines
	logic start_tgl_q;
	logic stop_tgl_q;

	always_ff @(negedge sda_in or posedge link_rst) begin
		if (link_rst) begin
			start_tgl_q <= 1'b0;
		end else if (link_scl) begin
			start_tgl_q <= ~start_tgl_q;
		end
	end

	always_ff @(posedge sda_in or posedge link_rst) begin
		if (link_rst) begin
			stop_tgl_q <= 1'b0;
		end else if (link_scl) begin
			stop_tgl_q <= ~stop_tgl_q;
		end
	end

	// ****************************************
	// status capture on clk
	// ****************************************
	// status bits are slow levels, so a per-bit two-flop sync is enough
	// the read byte is one snapshot taken on the last address bit, before the ack, so its bits
	// never mix two moments
	logic [7:0] status_meta_q;
	logic [7:0] status_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_meta_q <= 8'h00;
			status_q <= 8'h00;
		end else begin
			status_meta_q <= status_in;
			status_q <= status_meta_q;
		end
	end

	// ****************************************
	// serial engine on the link clock
	// ****************************************
	pmic_regs_pkg::phase_t phase_q;
	pmic_regs_pkg::phase_t next_phase_q;
	logic start_seen_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic ack_q;
	logic [1:0] sub_q;
	logic [7:0] tx_q;
	logic [7:0] hold_q [4];
	logic start_new;
	logic [7:0] rx_byte;
	logic byte_done;
	logic ack_clock;
	logic tx_bit;

	// start is seen before the first scl rise by the bus setup time,
	// so the toggle is stable when the engine samples it
	assign start_new = start_tgl_q != start_seen_q;
	assign rx_byte = {shift_q[6:0], sda_in};
	assign byte_done = bit_cnt_q == pmic_regs_pkg::LAST_DATA_BIT;
	assign ack_clock = bit_cnt_q == pmic_regs_pkg::ACK_BIT;
	assign tx_bit = tx_q[~bit_cnt_q[2:0]];

	// ****************************************
	// byte decode
	// ****************************************
	logic addr_write_hit;
	logic addr_read_hit;
	logic [1:0] sub_sel;
	logic in_idle;
	logic in_read;
	logic read_bit_low;

	assign addr_write_hit = rx_byte == pmic_regs_pkg::WRITE_ADDR_BYTE;
	assign addr_read_hit = rx_byte == pmic_regs_pkg::READ_ADDR_BYTE;
	// upper sub-address bits are dropped, so a stray sub-address aliases
	assign sub_sel = rx_byte[1:0];
	assign in_idle = phase_q == pmic_regs_pkg::PH_IDLE;
	assign in_read = phase_q == pmic_regs_pkg::PH_READ;
	// open drain: a one is sent by letting go of the line
	assign read_bit_low = ~tx_bit;

	// a stop leaves the engine where it is; only the next start realigns it,
	// so a master that stops mid-byte loses nothing already held

	always_ff @(posedge link_scl or posedge link_rst) begin
		if (link_rst) begin
			phase_q <= pmic_regs_pkg::PH_IDLE;
			next_phase_q <= pmic_regs_pkg::PH_IDLE;
			start_seen_q <= 1'b0;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			ack_q <= 1'b0;
			sub_q <= 2'h0;
			tx_q <= 8'h00;
			for (int i = 0; i < 4; i++) begin
				hold_q[i] <= pmic_regs_pkg::REG_RESET;
			end
		end else if (start_new) begin
			// a repeated start drops any unfinished cycle but keeps held data
			start_seen_q <= start_tgl_q;
			phase_q <= pmic_regs_pkg::PH_ADDR;
			bit_cnt_q <= 4'h1;
			shift_q <= {7'h00, sda_in};
			ack_q <= 1'b0;
		end else if (in_idle) begin
			bit_cnt_q <= 4'h0;
		end else if (ack_clock) begin
			bit_cnt_q <= 4'h0;
			ack_q <= 1'b0;
			phase_q <= next_phase_q;
		end else begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
			shift_q <= rx_byte;
			if (byte_done) begin
				case (phase_q)
					pmic_regs_pkg::PH_ADDR: begin
						if (addr_write_hit) begin
							ack_q <= 1'b1;
							next_phase_q <= pmic_regs_pkg::PH_SUB;
						end else if (addr_read_hit) begin
							ack_q <= 1'b1;
							tx_q <= status_q;
							next_phase_q <= pmic_regs_pkg::PH_READ;
						end else begin
							ack_q <= 1'b0;
							next_phase_q <= pmic_regs_pkg::PH_IDLE;
						end
					end
					pmic_regs_pkg::PH_SUB: begin
						sub_q <= sub_sel;
						ack_q <= 1'b1;
						next_phase_q <= pmic_regs_pkg::PH_DATA;
					end
					pmic_regs_pkg::PH_DATA: begin
						hold_q[sub_q] <= rx_byte;
						ack_q <= 1'b1;
						// a fourth byte is neither taken nor acknowledged
						next_phase_q <= pmic_regs_pkg::PH_IDLE;
					end
					pmic_regs_pkg::PH_READ: begin
						// the master answers; its ack or nack changes nothing
						ack_q <= 1'b0;
						next_phase_q <= pmic_regs_pkg::PH_IDLE;
					end
					default: begin
						ack_q <= 1'b0;
						next_phase_q <= pmic_regs_pkg::PH_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// data line drive on the falling edge
	// ****************************************
	// changing sda only while scl is low keeps it stable over the high phase
	logic sda_oe_q;
	logic sda_o_q;

	always_ff @(negedge link_scl or posedge link_rst) begin
		if (link_rst) begin
			sda_oe_q <= 1'b0;
			sda_o_q <= 1'b0;
		end else begin
			sda_o_q <= 1'b0;
			if (start_new) begin
				sda_oe_q <= 1'b0;
			end else if (ack_clock) begin
				sda_oe_q <= ack_q;
			end else if (in_read) begin
				sda_oe_q <= read_bit_low;
			end else begin
				sda_oe_q <= 1'b0;
			end
		end
	end

	// the pad only pulls down; the bus pull-up makes every one
	assign sda_o = sda_o_q;
	assign sda_oe = sda_oe_q;

	// ****************************************
	// stop crossing and command latches
	// ****************************************
	// held bytes are quiet once stop is seen (scl idles high), so they can
	// be copied on the synchronised stop event without a word crossing
	logic stop_meta_q;
	logic stop_sync_q;
	logic stop_prev_q;
	logic commit;
	pmic_regs_pkg::regulator_control_t regulator_q;
	pmic_regs_pkg::led_boost_control_t boost_q;
	pmic_regs_pkg::led_current_code_t current_q;
	pmic_regs_pkg::led_pulse_ratio_t ratio_q;

	// a clear in the same cycle as a stop wins, so a failing supply never
	// leaves half of a new setting applied
	assign commit = stop_sync_q ^ stop_prev_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stop_meta_q <= 1'b0;
			stop_sync_q <= 1'b0;
			stop_prev_q <= 1'b0;
		end else begin
			stop_meta_q <= stop_tgl_q;
			stop_sync_q <= stop_meta_q;
			stop_prev_q <= stop_sync_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regulator_q <= pmic_regs_pkg::REG_RESET;
			boost_q <= pmic_regs_pkg::REG_RESET;
			current_q <= pmic_regs_pkg::REG_RESET;
			ratio_q <= pmic_regs_pkg::REG_RESET;
		end else if (wipe_q) begin
			regulator_q <= pmic_regs_pkg::REG_RESET;
			boost_q <= pmic_regs_pkg::REG_RESET;
			current_q <= pmic_regs_pkg::REG_RESET;
			ratio_q <= pmic_regs_pkg::REG_RESET;
		end else if (commit) begin
			regulator_q <= hold_q[pmic_regs_pkg::SUB_REGULATOR];
			boost_q <= hold_q[pmic_regs_pkg::SUB_LED_BOOST];
			current_q <= hold_q[pmic_regs_pkg::SUB_LED_CURRENT];
			ratio_q <= hold_q[pmic_regs_pkg::SUB_LED_PULSE];
		end
	end

	// field meaning lives in the package structs: regulator enables,
	// low-load modes and edge rate; boost enable, ramp, mode, clock, edge
	assign regulator_control = regulator_q;
	assign led_boost_control = boost_q;
	assign led_current_code = current_q;
	assign led_pulse_ratio = ratio_q;

	// ****************************************
	// led pulse generator
	// ****************************************
	logic [11:0] tick_cnt_q;
	logic [3:0] pos_q;
	logic led_pulse_q;
	logic [1:0] clock_sel;
	logic [1:0] boost_mode;
	logic tick;
	logic period_end;
	logic pulse_mode;
	logic [11:0] tick_cnt_d;
	logic [3:0] pos_d;
	logic led_pulse_d;

	assign clock_sel = {boost_q.pulse_clock_sel_hi, boost_q.pulse_clock_sel_lo};
	assign boost_mode = {boost_q.boost_select_hi, boost_q.boost_select_lo};
	assign pulse_mode = boost_mode == pmic_regs_pkg::BOOST_PULSED;
	assign tick = tick_cnt_q == 12'h000;
	assign period_end = (pos_q + 4'h1) >= ratio_q.pulse_denominator;
	// tick counts are rounded down, so clock code 0 runs a hair fast; codes 1 to 3 wrap at 12 bits and run several times faster
	assign tick_cnt_d = tick ? tick_limit(clock_sel) - 12'h001 : tick_cnt_q - 12'h001;
	assign pos_d = period_end ? 4'h0 : pos_q + 4'h1;
	// outside pulsed mode the sink stays on whenever boost is on
	assign led_pulse_d = boost_q.boost_on & (~pulse_mode | pulse_level(
			ratio_q.pulse_numerator, ratio_q.pulse_denominator, pos_q));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt_q <= 12'h000;
			pos_q <= 4'h0;
			led_pulse_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			if (tick) begin
				pos_q <= pos_d;
			end
			led_pulse_q <= led_pulse_d;
		end
	end

	assign led_pulse_on = led_pulse_q;

endmodule : pmic_serial_control
